// ==== rtl/adcs_pkg.sv ====
// constants and types shared by the conversion sequencer files
package adcs_pkg;
   // register byte offsets on the bus
   localparam logic [4:0] ADDR_CTL = 5'h00;
   localparam logic [4:0] ADDR_RES1 = 5'h04;
   localparam logic [4:0] ADDR_RES4 = 5'h10;
   localparam logic [4:0] ADDR_OPT = 5'h14;
   localparam logic [2:0] RES_FIRST_WORD = 3'h1;
   // control/status field positions
   localparam int CTL_CCF_BIT = 7;
   localparam int CTL_ZERO_BIT = 6;
   localparam int CTL_SCAN_BIT = 5;
   localparam int CTL_GROUP_CONVERT_SELECT_BIT = 4;
   localparam logic [7:0] CTL_RESET = 8'h00;
   // option register field positions
   localparam int OPT_CONVERTER_CLOCK_SOURCE_SELECT_BIT = 6;
   localparam int OPT_DLY_BIT = 4;
   localparam logic [7:0] OPT_RESET = 8'h00;
   // conversion timing in converter ticks
   localparam logic [4:0] SAMPLE_LAST = 5'h0B;
   localparam logic [4:0] DECIDE_FIRST = 5'h0D;
   localparam logic [4:0] DECIDE_LAST = 5'h1B;
   localparam logic [4:0] CONV_LAST = 5'h1F;
   localparam logic [7:0] SAR_MSB = 8'h80;
   localparam logic [1:0] LAST_SLOT = 2'h3;
   // clock rates
   localparam int CLK_PERIOD_NS = 50;
   localparam int RC_FREQ_KHZ = 1500;
   localparam int RC_PERIOD_NS = 1000000 / RC_FREQ_KHZ;
   localparam int RC_DIV = RC_PERIOD_NS / CLK_PERIOD_NS;
   typedef enum logic [1:0] {ADCS_IDLE, ADCS_DELAY, ADCS_CONV} adcs_state_t;
endpackage : adcs_pkg

// ==== rtl/adcs_sar_if.sv ====
// link between the sequencer and the successive-approximation engine
`timescale 1ns/1ps
interface adcs_sar_if;
   logic tick;
   logic run;
   logic cmpHigh;
   logic sampSw;
   logic [7:0] dac;
   logic done;
   logic [7:0] result;
   modport seq (output tick, output run, output cmpHigh,
      input sampSw, input dac, input done, input result);
   modport core (input tick, input run, input cmpHigh,
      output sampSw, output dac, output done, output result);
endinterface : adcs_sar_if

// ==== rtl/adcs_sar_core.sv ====
// successive-approximation engine: 32 ticks per conversion, 12 of them sampling
`timescale 1ns/1ps
module adcs_sar_core (
   input wire logic clk,
   input wire logic rst_n,
   adcs_sar_if.core sar
);
   logic [4:0] cnt_reg;
   logic [4:0] cnt_next;
   logic [7:0] dac_reg;
   logic [7:0] dac_next;
   logic [7:0] trial_reg;
   logic [7:0] trial_next;
   logic samp_reg;
   logic samp_next;
   logic [5:0] since_reg;

   wire step = sar.tick && sar.run;
   // first trial is loaded as the hold closes, so the code never moves while sampling
   wire loadMsb = step && cnt_reg == adcs_pkg::SAMPLE_LAST + 5'h01;
   wire decide = step && cnt_reg[0] && cnt_reg >= adcs_pkg::DECIDE_FIRST
      && cnt_reg <= adcs_pkg::DECIDE_LAST;
   // keep the trial bit only when the input is at or above the trial level
   wire [7:0] kept = sar.cmpHigh ? dac_reg : (dac_reg & ~trial_reg);

   // dropping run discards the partial result so the channel is resampled
   assign cnt_next = !sar.run ? 5'h00 : (sar.tick ? cnt_reg + 5'h01 : cnt_reg);
   // window is ticks 1 to 12: opening at tick 0 would cut the first sample short
   // and close the switch again for a cycle as a halting sequence wraps
   assign samp_next = sar.run && cnt_next != 5'h00
      && cnt_next <= adcs_pkg::SAMPLE_LAST + 5'h01;
   assign trial_next = loadMsb ? adcs_pkg::SAR_MSB : (decide ? trial_reg >> 1 : trial_reg);
   // a full-scale input keeps every bit and saturates at the top code
   assign dac_next = loadMsb ? adcs_pkg::SAR_MSB
      : (decide ? (kept | (trial_reg >> 1)) : dac_reg);
   assign sar.done = step && cnt_reg == adcs_pkg::CONV_LAST;
   assign sar.result = dac_reg;
   assign sar.dac = dac_reg;
   assign sar.sampSw = samp_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_reg <= 5'h00;
         dac_reg <= 8'h00;
         trial_reg <= 8'h00;
         samp_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         dac_reg <= dac_next;
         trial_reg <= trial_next;
         samp_reg <= samp_next;
      end
   end

   // ticks since the current conversion began, for checking only
   always_ff @(posedge clk) begin
      if (!rst_n || !sar.run || sar.done) begin
         since_reg <= 6'h00;
      end else if (sar.tick) begin
         since_reg <= since_reg + 6'h01;
      end
   end

   conv_length_a: assert property (@(posedge clk) disable iff (!rst_n)
      sar.done |-> since_reg == 6'h1F)
      else $error("conversion did not take 32 converter ticks");
   halt_resample_a: assert property (@(posedge clk) disable iff (!rst_n)
      !sar.run |=> cnt_reg == 5'h00 && !sar.sampSw)
      else $error("suspended conversion not restarted from sampling");
   sample_window_a: assert property (@(posedge clk) disable iff (!rst_n)
      sar.sampSw |-> cnt_reg != 5'h00 && cnt_reg <= adcs_pkg::SAMPLE_LAST + 5'h01
         && $past(sar.run))
      else $error("sample switch closed outside the sample phase");
endmodule : adcs_sar_core

// ==== rtl/adc_conversion_sequencer.sv ====
// conversion sequencer: Avalon registers, channel sequencing, result storage
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ps
module adc_conversion_sequencer #(
   parameter int E_DIV = 1
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic stopModeActive,
   input wire logic waitModeActive,
   input wire logic compareHigh,
   output logic [3:0] analogMuxSel,
   output logic sampleSwitch,
   output logic [7:0] dacCode,
   output logic sequenceBusy
);
   adcs_sar_if sar ();

   logic waitReq_reg;
   logic [31:0] readData_reg;
   logic [7:0] ctl_reg;
   logic [7:0] ctlNext;
   logic [7:0] opt_reg;
   logic [7:0] optNext;
   logic [7:0] res_reg [4];
   adcs_pkg::adcs_state_t state_reg;
   adcs_pkg::adcs_state_t state_next;
   logic [1:0] slot_reg;
   logic [1:0] slot_next;
   logic ccf_reg;
   logic ccf_next;
   logic [3:0] mux_reg;
   logic [3:0] mux_next;
   logic busy_reg;
   logic [7:0] eCnt_reg;
   logic [7:0] rcCnt_reg;

   // ---------------- bus slave ----------------
   // one wait cycle on every access; the request completes at the next edge
   wire busReq = avs_read || avs_write;
   wire accept = busReq && !avs_waitrequest;
   wire lowLane = avs_byteenable[0];
   wire [2:0] wordIdx = avs_address[4:2];
   wire aligned = avs_address[1:0] == 2'b00;
   wire isCtl = avs_address == adcs_pkg::ADDR_CTL;
   wire isOpt = avs_address == adcs_pkg::ADDR_OPT;
   wire isRes = aligned && avs_address >= adcs_pkg::ADDR_RES1
      && avs_address <= adcs_pkg::ADDR_RES4;
   wire [1:0] resSel = 2'(wordIdx - adcs_pkg::RES_FIRST_WORD);
   wire wrCtl = accept && avs_write && isCtl && lowLane;
   wire wrOpt = accept && avs_write && isOpt && lowLane;

   // flag and the always-zero bit come from logic, not from storage
   wire [7:0] ctlView = {ccf_reg, 1'b0, ctl_reg[5:0]};
   wire [7:0] rdByte = isCtl ? ctlView
      : isOpt ? opt_reg
      : isRes ? res_reg[resSel]
      : 8'h00;

   assign ctlNext = wrCtl ? {2'b00, avs_writedata[5:0]} : ctl_reg;
   assign optNext = wrOpt ? avs_writedata[7:0] : opt_reg;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         waitReq_reg <= 1'b1;
         readData_reg <= 32'h00000000;
      end else begin
         waitReq_reg <= !(busReq && waitReq_reg);
         if (busReq && waitReq_reg) begin
            readData_reg <= {24'h000000, rdByte};
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctl_reg <= adcs_pkg::CTL_RESET;
         opt_reg <= adcs_pkg::OPT_RESET;
      end else begin
         ctl_reg <= ctlNext;
         opt_reg <= optNext;
      end
   end

   assign avs_waitrequest = waitReq_reg;
   assign avs_readdata = readData_reg;

   wire scanOn = ctl_reg[adcs_pkg::CTL_SCAN_BIT];
   wire groupOn = ctl_reg[adcs_pkg::CTL_GROUP_CONVERT_SELECT_BIT];
   wire clkSel = opt_reg[adcs_pkg::OPT_CONVERTER_CLOCK_SOURCE_SELECT_BIT];
   // recovery-delay bit is only stored; the settling wait is software's job
   wire stopDelayEn = opt_reg[adcs_pkg::OPT_DLY_BIT];

   // ---------------- converter clock ----------------
   // the RC source is modelled as an enable; noise isolation is not modelled
   wire eTick = eCnt_reg == 8'(E_DIV - 1);
   wire rcTick = rcCnt_reg == 8'(adcs_pkg::RC_DIV - 1);
   wire convTick = clkSel ? rcTick : eTick;

   always_ff @(posedge ref_clk) begin
      if (!rst_n || eTick) begin
         eCnt_reg <= 8'h00;
      end else begin
         eCnt_reg <= eCnt_reg + 8'h01;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n || rcTick) begin
         rcCnt_reg <= 8'h00;
      end else begin
         rcCnt_reg <= rcCnt_reg + 8'h01;
      end
   end

   // ---------------- sequencer ----------------
   wire lowPower = stopModeActive || waitModeActive;
   wire coreDone = sar.done;
   wire lastSlot = coreDone && slot_reg == adcs_pkg::LAST_SLOT;

   assign sar.tick = convTick;
   assign sar.run = state_reg == adcs_pkg::ADCS_CONV && !lowPower;
   assign sar.cmpHigh = compareHigh;

   // a control write always wins: it abandons whatever was running
   assign state_next = wrCtl ? adcs_pkg::ADCS_DELAY
      : (state_reg == adcs_pkg::ADCS_DELAY && convTick) ? adcs_pkg::ADCS_CONV
      : (lastSlot && !scanOn) ? adcs_pkg::ADCS_IDLE
      : state_reg;
   // slot wraps 3 to 0, so scan overwrites from the first register again
   assign slot_next = wrCtl ? 2'b00 : (coreDone ? slot_reg + 2'b01 : slot_reg);
   // write clearing beats a same-cycle set: that result belongs to the old sequence
   assign ccf_next = wrCtl ? 1'b0 : (lastSlot ? 1'b1 : ccf_reg);
   assign mux_next = ctlNext[adcs_pkg::CTL_GROUP_CONVERT_SELECT_BIT]
      ? {ctlNext[3:2], slot_next} : ctlNext[3:0];

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_reg <= adcs_pkg::ADCS_IDLE;
         slot_reg <= 2'b00;
         ccf_reg <= 1'b0;
         mux_reg <= 4'h0;
         busy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         slot_reg <= slot_next;
         ccf_reg <= ccf_next;
         mux_reg <= mux_next;
         busy_reg <= state_next != adcs_pkg::ADCS_IDLE;
      end
   end

   // results are written only by conversions; bus writes never reach them
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_res
         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               res_reg[gi] <= 8'h00;
            end else if (coreDone && slot_reg == 2'(gi)) begin
               res_reg[gi] <= sar.result;
            end
         end
      end
   endgenerate

   adcs_sar_core u_core (
      .clk(ref_clk),
      .rst_n(rst_n),
      .sar(sar)
   );

   assign analogMuxSel = mux_reg;
   assign sampleSwitch = sar.sampSw;
   assign dacCode = sar.dac;
   assign sequenceBusy = busy_reg;

   // ---------------- checks ----------------
   start_delay_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wrCtl ##1 convTick |=> state_reg == adcs_pkg::ADCS_CONV && slot_reg == 2'b00)
      else $error("sequence did not start one tick after the control write");
   write_clears_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wrCtl |=> !ccf_reg && state_reg == adcs_pkg::ADCS_DELAY)
      else $error("control write did not clear the flag and restart");
   abandon_seq_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wrCtl && state_reg == adcs_pkg::ADCS_CONV |=> !sar.run ##1 !sar.sampSw)
      else $error("running sequence not abandoned on control write");
   mux_select_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_reg == adcs_pkg::ADCS_CONV |-> analogMuxSel == (groupOn
         ? {ctl_reg[3:2], slot_reg} : ctl_reg[3:0]))
      else $error("multiplexer selects the wrong input");
   result_store_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      coreDone |=> res_reg[$past(slot_reg)] == $past(sar.result))
      else $error("result not stored in its slot");
   single_halt_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      lastSlot && !scanOn && !wrCtl |=> state_reg == adcs_pkg::ADCS_IDLE
         ##1 !sar.sampSw)
      else $error("non-scan sequence did not halt after four results");
   scan_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      lastSlot && scanOn && !wrCtl |=> slot_reg == 2'b00
         && state_reg == adcs_pkg::ADCS_CONV)
      else $error("scan mode did not wrap to the first register");
   flag_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      lastSlot && !wrCtl |=> ccf_reg ##1 (ccf_reg || $past(wrCtl)))
      else $error("flag not set after the fourth result");
   flag_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ccf_reg && !wrCtl |=> ccf_reg)
      else $error("flag dropped without a control write");
   zero_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      accept && avs_read && isCtl |-> !avs_readdata[6]
         && avs_readdata[7] == $past(ccf_reg))
      else $error("control readback shows bit 6 set or a stale flag");
   result_ro_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      accept && avs_write && isRes && !coreDone
         |=> res_reg[$past(resSel)] == $past(res_reg[resSel]))
      else $error("bus write altered a result register");
   answer_time_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      busReq && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered after one wait cycle");

   single_done_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
      lastSlot && !scanOn && !groupOn);
   group_done_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
      lastSlot && !scanOn && groupOn);
   scan_wrap_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
      lastSlot && scanOn && ccf_reg);
   suspend_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
      state_reg == adcs_pkg::ADCS_CONV && lowPower && stopDelayEn);
   abort_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
      wrCtl && state_reg == adcs_pkg::ADCS_CONV);
endmodule : adc_conversion_sequencer

// ==== testbench/adcs_analog_model.sv ====
// analog sources and reference levels seen through the converter input mux
`timescale 1ns/1ps
module adcs_analog_model (
   input wire logic ref_clk,
   input wire logic [3:0] muxSel,
   input wire logic sampleSwitch,
   input wire logic [7:0] dacCode,
   output logic compareHigh
);
   logic [7:0] chanLevel [16];
   logic [7:0] heldLevel;
   initial begin
      for (int i = 0; i < 16; i++) begin
         chanLevel[i] = 8'(i * 16 + 3);
      end
      heldLevel = 8'h00;
   end
   // hold cap tracks the selected input only while the switch is closed
   always @(posedge ref_clk) begin
      if (sampleSwitch) begin
         heldLevel <= chanLevel[muxSel];
      end
   end
   // levels in code units: low reference is 00, high reference is FF
   assign compareHigh = (heldLevel >= dacCode);
endmodule : adcs_analog_model

// ==== testbench/adc_conversion_sequencer_test.sv ====
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module adc_conversion_sequencer_test;
   logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable, analogMuxSel;
   logic stopModeActive, waitModeActive, compareHigh, sampleSwitch, sequenceBusy;
   logic [7:0] dacCode, x, lv;
   logic prevSw = 1'b0;
   int failures = 0;
   int check_count = 0;
   int cyc = 0, riseAt = 0, hiLen = 0, lastPeriod = 0, lastWidth = 0, r;

   adc_conversion_sequencer #(.E_DIV(1)) u_adc_conversion_sequencer (.ref_clk(ref_clk),
      .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .stopModeActive(stopModeActive), .waitModeActive(waitModeActive),
      .compareHigh(compareHigh), .analogMuxSel(analogMuxSel), .sampleSwitch(sampleSwitch),
      .dacCode(dacCode), .sequenceBusy(sequenceBusy));
   adcs_analog_model u_adcs_analog_model (.ref_clk(ref_clk), .muxSel(analogMuxSel),
      .sampleSwitch(sampleSwitch), .dacCode(dacCode), .compareHigh(compareHigh));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // sample window length and spacing between sample starts
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      prevSw <= sampleSwitch;
      hiLen <= sampleSwitch ? hiLen + 1 : 0;
      if (!sampleSwitch && prevSw) lastWidth <= hiLen;
      if (sampleSwitch && !prevSw) begin
         lastPeriod <= cyc - riseAt;
         riseAt <= cyc;
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done

   // one Avalon access; request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
      input logic [3:0] be, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= {24'h000000, d};
      avs_byteenable <= be;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         chk("waitrequest", 1'b0, 1'b1);
         test_done();
      end
      q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, 4'hF, q);
   endtask : wr

   task automatic rchk(input string nm, input logic [4:0] a, input logic [7:0] e);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, 4'hF, q);
      chk(nm, e, q);
   endtask : rchk

   task automatic res4(input logic [7:0] e [4]);
      for (int i = 0; i < 4; i++) begin
         rchk("result", 5'(adcs_pkg::ADDR_RES1 + 5'(4 * i)), e[i]);
      end
   endtask : res4

   task automatic wait_flag();
      logic [7:0] q;
      int n;
      n = 0;
      q = 8'h00;
      while (q[7] !== 1'b1 && n < 1000) begin
         bus(1'b0, adcs_pkg::ADDR_CTL, 8'h00, 4'hF, q);
         n++;
      end
      if (q[7] !== 1'b1) begin
         chk("flag wait", 1'b1, q[7]);
         test_done();
      end
   endtask : wait_flag

   task automatic lvl(input int ch, input logic [7:0] v);
      @(posedge ref_clk);
      u_adcs_analog_model.chanLevel[ch] <= v;
   endtask : lvl

   initial begin
      rst_n = 1'b0;
      {avs_read, avs_write, stopModeActive, waitModeActive} = 4'h0;
      avs_address = 5'h00;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'h0;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      rchk("ctl reset", adcs_pkg::ADDR_CTL, 8'h00);
      rchk("opt reset", adcs_pkg::ADDR_OPT, 8'h00);
      res4('{8'h00, 8'h00, 8'h00, 8'h00});
      wr(adcs_pkg::ADDR_CTL, 8'hC5);
      @(posedge ref_clk);
      chk("busy", 1'b1, sequenceBusy);
      rchk("ctl bits", adcs_pkg::ADDR_CTL, 8'h05);
      wait_flag();
      res4('{8'h53, 8'h53, 8'h53, 8'h53});
      chk("sample width", 12, lastWidth);
      chk("conv period", 32, lastPeriod);
      r = riseAt;
      repeat (100) @(posedge ref_clk);
      chk("halted", r, riseAt);
      chk("idle", 1'b0, sequenceBusy);
      lvl(12, 8'hFF);
      lvl(13, 8'h00);
      wr(adcs_pkg::ADDR_CTL, 8'hBE);
      rchk("ctl group", adcs_pkg::ADDR_CTL, 8'h3E);
      wait_flag();
      res4('{8'hFF, 8'h00, 8'hE3, 8'hF3});
      for (int i = 12; i < 16; i++) lvl(i, 8'(i * 5));
      repeat (200) @(posedge ref_clk);
      rchk("flag kept", adcs_pkg::ADDR_CTL, 8'hBE);
      res4('{8'h3C, 8'h41, 8'h46, 8'h4B});
      wr(adcs_pkg::ADDR_CTL, 8'h21);
      wait_flag();
      lvl(1, 8'h9C);
      repeat (200) @(posedge ref_clk);
      res4('{8'h9C, 8'h9C, 8'h9C, 8'h9C});
      wr(adcs_pkg::ADDR_CTL, 8'h02);
      rchk("flag clear", adcs_pkg::ADDR_CTL, 8'h02);
      repeat (40) @(posedge ref_clk);
      wr(adcs_pkg::ADDR_CTL, 8'h03);
      wait_flag();
      res4('{8'h33, 8'h33, 8'h33, 8'h33});
      // stop, then wait: the level moves while suspended, so a resample must see it
      for (int m = 0; m < 2; m++) begin
         lv = 8'h70 + 8'(m);
         wr(adcs_pkg::ADDR_CTL, 8'h04);
         repeat (20) @(posedge ref_clk);
         stopModeActive <= (m == 0);
         waitModeActive <= (m == 1);
         lvl(4, lv);
         repeat (30) @(posedge ref_clk);
         stopModeActive <= 1'b0;
         waitModeActive <= 1'b0;
         wait_flag();
         res4('{lv, lv, lv, lv});
      end
      wr(adcs_pkg::ADDR_RES1, 8'hAA);
      res4('{8'h71, 8'h71, 8'h71, 8'h71});
      rchk("unmapped", 5'h18, 8'h00);
      bus(1'b1, adcs_pkg::ADDR_CTL, 8'h0F, 4'h0, x);
      rchk("no byte lane", adcs_pkg::ADDR_CTL, 8'h84);
      // slow bus: software hands the converter to the RC clock, delay option on
      wr(adcs_pkg::ADDR_OPT, 8'h50);
      rchk("opt", adcs_pkg::ADDR_OPT, 8'h50);
      wr(adcs_pkg::ADDR_CTL, 8'h01);
      wait_flag();
      res4('{8'h9C, 8'h9C, 8'h9C, 8'h9C});
      chk("rc period", 32 * adcs_pkg::RC_DIV, lastPeriod);
      chk("rc width", 12 * adcs_pkg::RC_DIV, lastWidth);
      test_done();
   end
endmodule : adc_conversion_sequencer_test
